// ### rtl/failsafe_init_window_watchdog.v
// fail-safe init phase, complement-protected registers and window watchdog
//
// Operation
// [RULE_01] enter init phase when the reset output pin is released after power-on
// [RULE_02] host writes a value, then its bitwise complement into the partner register
// [RULE_03] only functional bits are compared; reserved bits are ignored
// [RULE_04] continuously compare register with complement; flag mismatch, clear on exact inverse
// [RULE_05] mismatch reporting is active only after init phase closed
// [RULE_06] first good refresh closes init; must come before selectable init timeout; the code only raises the init timeout interrupt and stays in init
// [RULE_07] re-enter request returns to init phase from any other state; the code acts on it only in the run state
// [RULE_08] each period is a closed phase then an open phase
// [RULE_09] good refresh is a correct answer inside the open phase
// [RULE_10] bad refresh: wrong answer, no answer, or answer in closed phase
// [RULE_11] every good or bad refresh restarts a fresh period at once
// [RULE_12] four-bit period field: 0 disables, 1..15 give 1 to 1024 ms, default 3 ms
// [RULE_13] new period takes effect only after the next refresh; the code also reloads it on re-entry into init with the watchdog off
// [RULE_14] disable code accepted only in init phase, effective when init closes
// [RULE_15] three-bit duty field sets closed share, applied after the next refresh
// [RULE_16] all timing derives from the single fail-safe clock
// [RULE_17] bad refresh adds two to the error count, good refresh subtracts one
// [RULE_18] period timer counts clocks; closed boundary is duty fraction of period
// [RULE_19] period and duty return to defaults on power-on reset
`timescale 1ns/100ps
`default_nettype none
`include "fs_watchdog_defs.vh"

module failsafe_init_window_watchdog (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [7:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire reset_out_pin_in,
    input wire [1:0] init_timeout_select_in,
    output reg [15:0] rdata_out,
    output reg irq_out,
    output reg fs_init_phase_out,
    output reg shadow_mismatch_flag_out,
    output reg window_open_out
);

    localparam ST_WAIT_RELEASE = 2'b00;
    localparam ST_INIT = 2'b01;
    localparam ST_RUN = 2'b10;
    localparam IRQ_W = `IRQ_COUNT;

    // synchronisers for pin-side inputs
    reg rst_pin_meta;
    reg rst_pin_sync;
    reg [1:0] tsel_meta;
    reg [1:0] tsel_sync;

    reg [1:0] state;
    reg [1:0] next_state;

    reg [15:0] init_data;
    reg [15:0] complement_register;
    reg [15:0] seed;
    reg [3:0] window_period_sel;
    reg [2:0] duty_split_sel;
    reg [3:0] active_period;
    reg [2:0] active_duty;
    reg [IRQ_W-1:0] irq_mask;
    wire [IRQ_W-1:0] irq_status;
    reg [3:0] refresh_fault_count;
    reg mismatch_prev;

    reg [11:0] sub_cnt;
    reg [14:0] win_cnt;
    reg [15:0] init_ms;
    reg [3:0] ms_sub;

    // period length in ms for a period code
    function [10:0] period_ms;
        input [3:0] code;
        begin
            case (code)
                4'h1: period_ms = 11'd1;
                4'h2: period_ms = 11'd2;
                4'h3: period_ms = 11'd3;
                4'h4: period_ms = 11'd4;
                4'h5: period_ms = 11'd6;
                4'h6: period_ms = 11'd8;
                4'h7: period_ms = 11'd12;
                4'h8: period_ms = 11'd16;
                4'h9: period_ms = 11'd24;
                4'hA: period_ms = 11'd32;
                4'hB: period_ms = 11'd64;
                4'hC: period_ms = 11'd128;
                4'hD: period_ms = 11'd256;
                4'hE: period_ms = 11'd512;
                4'hF: period_ms = 11'd1024;
                default: period_ms = 11'd0;
            endcase
        end
    endfunction

    // closed share of a period in sixteenths
    function [3:0] closed_16ths;
        input [2:0] code;
        begin
            case (code)
                3'h0: closed_16ths = 4'd5;
                3'h1: closed_16ths = 4'd6;
                3'h3: closed_16ths = 4'd10;
                3'h4: closed_16ths = 4'd11;
                default: closed_16ths = 4'd8;
            endcase
        end
    endfunction

    function [15:0] init_timeout_ms;
        input [1:0] code;
        begin
            case (code)
                2'h0: init_timeout_ms = `INIT_TO_MS_0;
                2'h1: init_timeout_ms = `INIT_TO_MS_1;
                2'h2: init_timeout_ms = `INIT_TO_MS_2;
                default: init_timeout_ms = `INIT_TO_MS_3;
            endcase
        end
    endfunction

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rst_pin_meta <= 1'b0;
            rst_pin_sync <= 1'b0;
            tsel_meta <= 2'h0;
            tsel_sync <= 2'h0;
        end else begin
            rst_pin_meta <= reset_out_pin_in;
            rst_pin_sync <= rst_pin_meta;
            tsel_meta <= init_timeout_select_in;
            tsel_sync <= tsel_meta;
        end
    end

    // register port decode
    wire wr_data = wr_in && (addr_in == `ADDR_INIT_DATA);
    wire wr_comp = wr_in && (addr_in == `ADDR_COMPLEMENT);
    wire wr_cfg = wr_in && (addr_in == `ADDR_WINDOW_CONFIG);
    wire wr_io = wr_in && (addr_in == `ADDR_SAFETY_IO);
    wire wr_answer = wr_in && (addr_in == `ADDR_ANSWER);
    wire wr_seed = wr_in && (addr_in == `ADDR_SEED);
    wire wr_mask = wr_in && (addr_in == `ADDR_IRQ_MASK);
    wire rd_irq = rd_in && (addr_in == `ADDR_IRQ_STATUS);

    wire in_init = (state == ST_INIT);
    wire wd_disabled = (active_period == `PERIOD_DISABLE);

    // [RULE_16] sub-tick of 1/16 ms from the one clock
    wire sub_tick = (sub_cnt == `SUBTICK_CYCLES - 1);

    // [RULE_18] period and closed boundary in sub-ticks
    wire [14:0] period_len = {period_ms(active_period), 4'h0};
    wire [14:0] closed_len = period_ms(active_period) * closed_16ths(active_duty);

    // [RULE_08] open once the closed share has elapsed
    wire window_open = (win_cnt >= closed_len);
    wire period_end = sub_tick && (win_cnt == period_len - 15'd1);

    wire wd_running = (state != ST_WAIT_RELEASE) && !wd_disabled;
    wire answer_ok = (wdata_in == seed);

    // [RULE_09] correct answer inside open phase
    wire good_refresh = wd_running && wr_answer && window_open && answer_ok;
    // [RULE_10] wrong data in open phase
    wire bad_data = wd_running && wr_answer && window_open && !answer_ok;
    // [RULE_10] answer in closed phase, or no answer by period end
    wire bad_timing = wd_running && ((wr_answer && !window_open) || (period_end && !wr_answer));
    wire bad_refresh = bad_data || bad_timing;
    // [RULE_11] any refresh starts a new period
    wire restart_period = good_refresh || bad_refresh;

    wire init_ms_tick = sub_tick && (ms_sub == `SUBTICKS_PER_MS - 1);
    // [RULE_06] timeout if init not closed in time
    wire init_timeout = in_init && init_ms_tick && (init_ms == init_timeout_ms(tsel_sync) - 16'd1);

    // [RULE_03] only functional bits take part
    // [RULE_04] exact inverse clears the flag
    wire pair_mismatch = (((init_data ^ complement_register) & `INIT_FUNC_MASK) != `INIT_FUNC_MASK);
    // [RULE_05] reporting only after init closed
    wire mismatch_live = (state == ST_RUN) && pair_mismatch;

    wire reenter = wr_io && wdata_in[`REENTER_BIT];

    always @* begin
        next_state = state;
        case (state)
            ST_WAIT_RELEASE: begin
                // [RULE_01] init on pin release
                if (rst_pin_sync) begin
                    next_state = ST_INIT;
                end
            end
            ST_INIT: begin
                // [RULE_06] first good refresh closes init
                if (good_refresh) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                // [RULE_07] re-enter from the run state only; a request while waiting for pin release is ignored
                if (reenter) begin
                    next_state = ST_INIT;
                end
            end
            default: begin
                next_state = ST_WAIT_RELEASE;
            end
        endcase
        if (!rst_pin_sync) begin
            next_state = ST_WAIT_RELEASE;
        end
    end

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            state <= ST_WAIT_RELEASE;
        end else begin
            state <= next_state;
        end
    end

    // time base restarts with each period, else the closed phase could lose up to a sub-tick
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            sub_cnt <= 12'h000;
            win_cnt <= 15'h0000;
        end else begin
            // [RULE_11] restart on refresh, init entry or when stopped
            if (restart_period || !wd_running || (next_state == ST_INIT && state != ST_INIT)) begin
                sub_cnt <= 12'h000;
                win_cnt <= 15'h0000;
            end else if (sub_tick) begin
                sub_cnt <= 12'h000;
                win_cnt <= win_cnt + 15'h0001;
            end else begin
                sub_cnt <= sub_cnt + 12'h001;
            end
        end
    end

    // init timeout counter, rearmed on each expiry so the host can still close init
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            init_ms <= 16'h0000;
            ms_sub <= 4'h0;
        end else if (!in_init || init_timeout) begin
            init_ms <= 16'h0000;
            ms_sub <= 4'h0;
        end else if (sub_tick) begin
            ms_sub <= ms_sub + 4'h1;
            if (init_ms_tick) begin
                init_ms <= init_ms + 16'h0001;
            end
        end
    end

    // software registers
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            init_data <= `INIT_DATA_RESET;
            complement_register <= `COMPLEMENT_RESET;
            seed <= `SEED_RESET;
            irq_mask <= {IRQ_W{1'b0}};
            // [RULE_19] defaults on power-on reset
            window_period_sel <= `PERIOD_DEFAULT;
            duty_split_sel <= `DUTY_DEFAULT;
        end else begin
            // [RULE_02] protected pair written in init phase only
            if (wr_data && in_init) begin
                init_data <= wdata_in;
            end
            if (wr_comp && in_init) begin
                complement_register <= wdata_in;
            end
            if (wr_seed && in_init) begin
                seed <= wdata_in;
            end
            if (wr_mask) begin
                irq_mask <= wdata_in[IRQ_W-1:0];
            end
            if (wr_cfg) begin
                duty_split_sel <= wdata_in[`DUTY_MSB:`DUTY_LSB];
                // [RULE_14] disable code refused outside init
                if (in_init || wdata_in[`PERIOD_MSB:`PERIOD_LSB] != `PERIOD_DISABLE) begin
                    window_period_sel <= wdata_in[`PERIOD_MSB:`PERIOD_LSB];
                end
            end
        end
    end

    // settings in force; a refresh copies the pending ones (a disable only as init closes); re-entry into init with the watchdog off reloads the period
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            active_period <= `PERIOD_DEFAULT;
            active_duty <= `DUTY_DEFAULT;
        end else if (restart_period) begin
            // [RULE_13] period applied from the next period
            // [RULE_15] duty applied from the next period
            active_duty <= duty_split_sel;
            // [RULE_14] disable only takes effect as init closes
            if (window_period_sel != `PERIOD_DISABLE || (in_init && good_refresh)) begin
                active_period <= window_period_sel;
            end
        end else if (next_state == ST_INIT && state == ST_RUN && wd_disabled) begin
            // re-entered init with the watchdog off: resume at the pending or default period
            active_period <= (window_period_sel == `PERIOD_DISABLE) ? `PERIOD_DEFAULT : window_period_sel;
        end
    end

    // [RULE_17] error counter, saturating both ways
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            refresh_fault_count <= 4'h0;
        end else if (bad_refresh) begin
            if (refresh_fault_count > `ERR_MAX - `ERR_STEP_BAD) begin
                refresh_fault_count <= `ERR_MAX;
            end else begin
                refresh_fault_count <= refresh_fault_count + `ERR_STEP_BAD;
            end
        end else if (good_refresh && refresh_fault_count != 4'h0) begin
            refresh_fault_count <= refresh_fault_count - `ERR_STEP_GOOD;
        end
    end

    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            mismatch_prev <= 1'b0;
        end else begin
            mismatch_prev <= mismatch_live;
        end
    end

    wire [IRQ_W-1:0] irq_event;
    assign irq_event[`IRQ_GOOD] = good_refresh;
    assign irq_event[`IRQ_BAD_DATA] = bad_data;
    assign irq_event[`IRQ_BAD_TIMING] = bad_timing;
    assign irq_event[`IRQ_INIT_TIMEOUT] = init_timeout;
    assign irq_event[`IRQ_MISMATCH] = mismatch_live && !mismatch_prev;

    // sticky status, cleared by reading; a new event in the read cycle survives
    genvar gi;
    generate
        for (gi = 0; gi < IRQ_W; gi = gi + 1) begin : g_irq
            reg sticky;
            always @(posedge clk_sys_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    sticky <= 1'b0;
                end else if (irq_event[gi]) begin
                    sticky <= 1'b1;
                end else if (rd_irq) begin
                    sticky <= 1'b0;
                end
            end
            assign irq_status[gi] = sticky;
        end
    endgenerate

    // read data and flopped outputs
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            rdata_out <= 16'h0000;
            irq_out <= 1'b0;
            fs_init_phase_out <= 1'b0;
            shadow_mismatch_flag_out <= 1'b0;
            window_open_out <= 1'b0;
        end else begin
            irq_out <= |(irq_status & irq_mask);
            fs_init_phase_out <= in_init;
            shadow_mismatch_flag_out <= mismatch_live;
            window_open_out <= wd_running && window_open;
            rdata_out <= 16'h0000;
            if (rd_in) begin
                case (addr_in)
                    `ADDR_INIT_DATA: rdata_out <= init_data;
                    `ADDR_COMPLEMENT: rdata_out <= complement_register;
                    `ADDR_WINDOW_CONFIG: begin
                        rdata_out[`PERIOD_MSB:`PERIOD_LSB] <= window_period_sel;
                        rdata_out[`DUTY_MSB:`DUTY_LSB] <= duty_split_sel;
                    end
                    `ADDR_SEED: rdata_out <= seed;
                    `ADDR_STATE_STATUS: begin
                        rdata_out[`ST_INIT_BIT] <= in_init;
                        rdata_out[`ST_MISMATCH_BIT] <= mismatch_live;
                        rdata_out[`ST_OPEN_BIT] <= wd_running && window_open;
                        rdata_out[`ST_DISABLED_BIT] <= wd_disabled;
                        rdata_out[`ST_ERRCNT_MSB:`ST_ERRCNT_LSB] <= refresh_fault_count;
                    end
                    `ADDR_IRQ_STATUS: rdata_out[IRQ_W-1:0] <= irq_status;
                    `ADDR_IRQ_MASK: rdata_out[IRQ_W-1:0] <= irq_mask;
                    default: rdata_out <= 16'h0000;
                endcase
            end
        end
    end

endmodule // failsafe_init_window_watchdog

`default_nettype wire

// ### rtl/fs_watchdog_defs.vh
// constants of the fail-safe init phase and window watchdog block
`ifndef FS_WATCHDOG_DEFS_VH
`define FS_WATCHDOG_DEFS_VH

// clock and time base
`define CLK_PERIOD_NS 20
`define SUBTICK_NS 62500
`define SUBTICKS_PER_MS 16
`define SUBTICK_CYCLES (`SUBTICK_NS / `CLK_PERIOD_NS)

// register indices on the plain register port
`define ADDR_INIT_DATA 8'h00
`define ADDR_COMPLEMENT 8'h01
`define ADDR_WINDOW_CONFIG 8'h02
`define ADDR_SAFETY_IO 8'h03
`define ADDR_ANSWER 8'h04
`define ADDR_SEED 8'h05
`define ADDR_STATE_STATUS 8'h06
`define ADDR_IRQ_STATUS 8'h07
`define ADDR_IRQ_MASK 8'h08

// window_config fields
`define PERIOD_LSB 0
`define PERIOD_MSB 3
`define DUTY_LSB 4
`define DUTY_MSB 6
`define PERIOD_DEFAULT 4'h3
`define PERIOD_DISABLE 4'h0
`define DUTY_DEFAULT 3'h2

// safety_io_control fields
`define REENTER_BIT 0

// functional bits of the protected init register; the rest are reserved
`define INIT_FUNC_MASK 16'h0FFF
`define INIT_DATA_RESET 16'h0000
`define COMPLEMENT_RESET 16'h0FFF
`define SEED_RESET 16'h5AB2

// fs_state_status fields
`define ST_INIT_BIT 0
`define ST_MISMATCH_BIT 1
`define ST_OPEN_BIT 2
`define ST_DISABLED_BIT 3
`define ST_ERRCNT_LSB 4
`define ST_ERRCNT_MSB 7

// interrupt status bits
`define IRQ_GOOD 0
`define IRQ_BAD_DATA 1
`define IRQ_BAD_TIMING 2
`define IRQ_INIT_TIMEOUT 3
`define IRQ_MISMATCH 4
`define IRQ_COUNT 5

// watchdog error counter
`define ERR_STEP_BAD 4'h2
`define ERR_STEP_GOOD 4'h1
`define ERR_MAX 4'hF

// init timeout per one-time-programmable select code, in ms
`define INIT_TO_MS_0 16'd256
`define INIT_TO_MS_1 16'd1024
`define INIT_TO_MS_2 16'd2048
`define INIT_TO_MS_3 16'd4096

`endif

// ### verif/fs_wd_monitor.sv
// assertion checker on the ports of the fail-safe watchdog
`timescale 1ns/100ps
`default_nettype none
module fs_wd_monitor #(
    parameter int CLOSED_MIN = 15620
) (
    input wire clk_sys_in,
    input wire reset_n_in,
    input wire [7:0] addr_in,
    input wire [15:0] wdata_in,
    input wire wr_in,
    input wire reset_out_pin_in,
    input wire fs_init_phase_out,
    input wire shadow_mismatch_flag_out,
    input wire window_open_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);
    logic [16:0] closed_cnt;
    wire answer = wr_in && addr_in == 8'h04;
    // shortest legal closed phase: 1 ms at 31.25 %, a few clocks of slack for output lag
    always @(posedge clk_sys_in or negedge reset_n_in) begin
        if (!reset_n_in)
            closed_cnt <= 17'h00000;
        else if (window_open_out)
            closed_cnt <= 17'h00000;
        else if (closed_cnt != 17'h1FFFF)
            closed_cnt <= closed_cnt + 17'h00001;
    end
    property p_init_wait;
        !reset_out_pin_in [*4] |=> !fs_init_phase_out;
    endproperty
    a_init_wait: assert property (p_init_wait) else $error("init without released pin");
    property p_flag_hidden;
        fs_init_phase_out && $past(fs_init_phase_out) |-> !shadow_mismatch_flag_out;
    endproperty
    a_flag_hidden: assert property (p_flag_hidden) else $error("mismatch shown in init");
    property p_good_closes;
        answer && wdata_in == 16'h5AB2 && window_open_out && $past(window_open_out) && fs_init_phase_out
            |-> ##[1:3] !fs_init_phase_out;
    endproperty
    a_good_closes: assert property (p_good_closes) else $error("good refresh kept init");
    property p_reenter;
        wr_in && addr_in == 8'h03 && wdata_in[0] && !fs_init_phase_out && !$past(fs_init_phase_out)
            && reset_out_pin_in && $past(reset_out_pin_in, 4) |-> ##[1:3] fs_init_phase_out;
    endproperty
    a_reenter: assert property (p_reenter) else $error("init not re-entered");
    property p_closed_hold;
        $fell(window_open_out) |-> !window_open_out [*8];
    endproperty
    a_closed_hold: assert property (p_closed_hold) else $error("closed phase too short");
    property p_closed_keep;
        (answer && !window_open_out && fs_init_phase_out) ##1 !window_open_out |-> fs_init_phase_out;
    endproperty
    a_closed_keep: assert property (p_closed_keep) else $error("closed answer ended init");
    property p_restart;
        answer && window_open_out |-> ##[1:3] !window_open_out;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart after refresh");
    property p_closed_min;
        $rose(window_open_out) |-> closed_cnt >= CLOSED_MIN;
    endproperty
    a_closed_min: assert property (p_closed_min) else $error("open phase came early");
endmodule // fs_wd_monitor
bind failsafe_init_window_watchdog fs_wd_monitor u_mon (.clk_sys_in, .reset_n_in, .addr_in, .wdata_in,
    .wr_in, .reset_out_pin_in, .fs_init_phase_out, .shadow_mismatch_flag_out, .window_open_out);
`default_nettype wire

// ### verif/mcu_host_model.sv
// host microcontroller model for the register port
`timescale 1ns/100ps
`default_nettype none
`include "fs_watchdog_defs.vh"
module mcu_host_model (
    input wire logic clk_sys_in,
    input wire logic [15:0] rdata_in,
    output var logic [7:0] addr_out,
    output var logic [15:0] wdata_out,
    output var logic wr_out,
    output var logic rd_out,
    output var logic pin_out
);
    initial begin
        addr_out = 8'hFF;
        wdata_out = 16'hFFFF;
        wr_out = 1'b0;
        rd_out = 1'b0;
        pin_out = 1'b0;
    end
    task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        wdata_out <= d;
        wr_out <= 1'b1;
        @(posedge clk_sys_in);
        wr_out <= 1'b0;
        // an idle bus shows no stale value
        addr_out <= ~a;
        wdata_out <= ~d;
    endtask
    task automatic reg_read(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk_sys_in);
        addr_out <= a;
        rd_out <= 1'b1;
        @(posedge clk_sys_in);
        rd_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
    endtask
    task automatic write_pair(input logic [15:0] d);
        reg_write(`ADDR_INIT_DATA, d);
        reg_write(`ADDR_COMPLEMENT, ~d & `INIT_FUNC_MASK);
    endtask
    task automatic release_pin;
        @(posedge clk_sys_in);
        pin_out <= 1'b1;
    endtask
endmodule // mcu_host_model
`default_nettype wire

// ### verif/failsafe_init_window_watchdog_tb.sv
// self-checking testbench of the fail-safe init phase and window watchdog
`timescale 1ns/100ps
`default_nettype none
`include "fs_watchdog_defs.vh"
module failsafe_init_window_watchdog_tb;
    logic clk_sys_in;
    logic reset_n_in;
    wire [7:0] addr_in;
    wire [15:0] wdata_in;
    wire wr_in;
    wire rd_in;
    wire reset_out_pin_in;
    wire [15:0] rdata_out;
    wire irq_out;
    wire fs_init_phase_out;
    wire shadow_mismatch_flag_out;
    wire window_open_out;
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    logic [15:0] rv;
    localparam logic [15:0] SEED = `SEED_RESET;
    initial begin
        clk_sys_in = 1'b0;
        forever #10 clk_sys_in = ~clk_sys_in;
    end
    failsafe_init_window_watchdog dut (.clk_sys_in(clk_sys_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .reset_out_pin_in(reset_out_pin_in),
        .init_timeout_select_in(2'b00), .rdata_out(rdata_out), .irq_out(irq_out),
        .fs_init_phase_out(fs_init_phase_out), .shadow_mismatch_flag_out(shadow_mismatch_flag_out),
        .window_open_out(window_open_out));
    mcu_host_model u_mcu (.clk_sys_in(clk_sys_in), .rdata_in(rdata_out), .addr_out(addr_in),
        .wdata_out(wdata_in), .wr_out(wr_in), .rd_out(rd_in), .pin_out(reset_out_pin_in));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] exp, input string msg);
        u_mcu.reg_read(a, rv);
        chk(rv, exp, msg);
    endtask
    task automatic edges(input int k);
        repeat (k) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic wait_open(input logic lvl, input int bound);
        n = 0;
        while (window_open_out !== lvl) begin
            edges(1);
            n++;
            if (n > bound) begin
                n_fail++;
                $display("mismatch at %0t: window wait ran out", $time);
                stop_test();
            end
        end
    endtask
    task automatic t_reset_values;
        rchk(`ADDR_WINDOW_CONFIG, 16'h0023, "config reset");
        rchk(`ADDR_SEED, 16'h5AB2, "seed reset");
        rchk(`ADDR_COMPLEMENT, 16'h0FFF, "complement reset");
        rchk(`ADDR_IRQ_MASK, 16'h0000, "mask reset");
        rchk(8'h20, 16'h0000, "unmapped read");
        chk(fs_init_phase_out, 1'b0, "init before pin");
        u_mcu.release_pin();
        edges(4);
        chk(fs_init_phase_out, 1'b1, "init after pin");
        rchk(`ADDR_STATE_STATUS, 16'h0001, "status in init");
        $display("done reset values");
    endtask
    task automatic t_init_setup;
        u_mcu.reg_write(`ADDR_INIT_DATA, 16'h0ABC);
        u_mcu.reg_write(`ADDR_WINDOW_CONFIG, 16'h0001);
        edges(3);
        chk(shadow_mismatch_flag_out, 1'b0, "flag in init");
        // early answer restarts with the pending 1 ms, 31.25 % window
        u_mcu.reg_write(`ADDR_ANSWER, SEED);
        wait_open(1'b1, 16000);
        chk(n >= 15618 && n <= 15628, 1'b1, "closed length");
        chk(fs_init_phase_out, 1'b1, "init kept");
        chk(irq_out, 1'b0, "masked irq");
        rchk(`ADDR_STATE_STATUS, 16'h0025, "count after bad");
        rchk(`ADDR_IRQ_STATUS, 16'h0004, "bad timing");
        rchk(`ADDR_IRQ_STATUS, 16'h0000, "read clears");
        $display("done init setup");
    endtask
    task automatic t_first_good;
        u_mcu.reg_write(`ADDR_IRQ_MASK, 16'h001F);
        u_mcu.reg_write(`ADDR_ANSWER, SEED);
        edges(5);
        chk(fs_init_phase_out, 1'b0, "init closed");
        chk(shadow_mismatch_flag_out, 1'b1, "flag shown");
        chk(irq_out, 1'b1, "irq raised");
        rchk(`ADDR_IRQ_STATUS, 16'h0011, "good and mismatch");
        edges(3);
        chk(irq_out, 1'b0, "irq cleared");
        rchk(`ADDR_STATE_STATUS, 16'h0012, "count after good");
        u_mcu.reg_write(`ADDR_WINDOW_CONFIG, 16'h0000);
        rchk(`ADDR_WINDOW_CONFIG, 16'h0001, "disable refused");
        $display("done first good");
    endtask
    task automatic t_bad_reenter;
        wait_open(1'b1, 40000);
        u_mcu.reg_write(`ADDR_ANSWER, ~SEED);
        u_mcu.reg_write(8'h03, 16'h0001);
        edges(3);
        chk(fs_init_phase_out, 1'b1, "init re-entered");
        chk(shadow_mismatch_flag_out, 1'b0, "flag hidden");
        u_mcu.write_pair(16'h0ABC);
        u_mcu.reg_write(`ADDR_WINDOW_CONFIG, 16'h0000);
        rchk(`ADDR_IRQ_STATUS, 16'h0002, "bad data");
        wait_open(1'b1, 60000);
        wait_open(1'b0, 36000);
        chk(n >= 34370 && n <= 34380, 1'b1, "open length");
        rchk(`ADDR_IRQ_STATUS, 16'h0004, "missed refresh");
        wait_open(1'b1, 16000);
        u_mcu.reg_write(`ADDR_ANSWER, SEED);
        edges(5);
        chk(fs_init_phase_out, 1'b0, "init closed again");
        chk(shadow_mismatch_flag_out, 1'b0, "pair restored");
        rchk(`ADDR_STATE_STATUS, 16'h0048, "disabled, count 4");
        u_mcu.reg_write(`ADDR_ANSWER, ~SEED);
        edges(20);
        chk(window_open_out, 1'b0, "no window");
        rchk(`ADDR_STATE_STATUS, 16'h0048, "answer ignored");
        $display("done bad data and re-entry");
    endtask
    initial begin
        reset_n_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        reset_n_in <= 1'b1;
        t_reset_values();
        t_init_setup();
        t_first_good();
        t_bad_reenter();
        stop_test();
    end
endmodule // failsafe_init_window_watchdog_tb
`default_nettype wire
